// ==== rtl/mii_phy_cfg.svh ====
// Timing constants for the PHY-side MII timing block
`ifndef MII_PHY_CFG_SVH
`define MII_PHY_CFG_SVH

`define CLK_NS 25
`define CYC_UP(ns) ((((ns) + `CLK_NS - 1) / `CLK_NS) < 1 ? 1 : \
	(((ns) + `CLK_NS - 1) / `CLK_NS))
`define CYC_DN(ns) ((((ns) / `CLK_NS) < 1) ? 1 : ((ns) / `CLK_NS))

`define BIT100_NS 10
`define BIT10_NS 100
`define HALF100_NS 16
`define HALF10_NS 200
`define SER_TX_HI_NS 25
`define SER_TX_LO_NS 75
`define SER_RX_HALF_NS 50

`define TX100_LAT_BITS 6
`define TX10_LAT_TENTHS 35
`define CRS_ON_BITS 20
`define CRS_OFF_BITS 24

`define SYNC_LAT 4
`define RX_STRETCH_CYC 4

`define TX100_LAT_CYC `CYC_DN(`TX100_LAT_BITS * `BIT100_NS)
`define TX10_LAT_CYC `CYC_DN(`TX10_LAT_TENTHS * `BIT10_NS / 10)
`define CRS_ON_CYC (`CYC_DN(`CRS_ON_BITS * `BIT100_NS) - `SYNC_LAT)
`define CRS_OFF_CYC (`CYC_DN(`CRS_OFF_BITS * `BIT100_NS) - `SYNC_LAT)

`endif

// ==== rtl/mii_phy_pkg.sv ====
// Types shared by the PHY-side MII timing block
package mii_phy_pkg;
	typedef enum logic [1:0] {MODE_100, MODE_10_NIB, MODE_10_SER} mode_t;
	typedef enum logic {RS_RUN, RS_STRETCH} rx_st_t;
	typedef struct packed {
		logic en;
		logic [3:0] d;
	} mii_tx_t;
	typedef struct packed {
		logic dv;
		logic [3:0] d;
	} mii_rx_t;
endpackage

// ==== rtl/mii_phy_timing.sv ====
// PHY-side MII clocks, transmit sampling, receive launch and line latency
`timescale 1ns/1ps
`include "mii_phy_cfg.svh"
module mii_phy_timing
	import mii_phy_pkg::*;
#(
	parameter int STRETCH_CYC = `RX_STRETCH_CYC
)
(
	input wire logic clk_sys, // System clock, 40 MHz
	input wire logic rstn, // Async reset, active low
	input wire mode_t mode, // Speed and format, static while linked
	output logic tx_clk, // Transmit clock to the MAC
	input wire mii_tx_t mac_tx, // Transmit enable and data from the MAC
	output logic rx_clk, // Receive clock to the MAC
	output mii_rx_t mac_rx, // Receive valid and data to the MAC
	output logic crs, // Carrier sense to the MAC
	output mii_tx_t line_tx, // Delayed transmit stream toward the line
	input wire logic [3:0] line_rxd, // Received data from the line
	input wire logic line_rx_dv, // Received data valid from the line
	input wire logic line_act, // High from first J bit to first T bit
	input wire logic line_sd, // Signal detect
	input wire logic rec_sel // High when recovered clock is selected
);
	logic [7:0] s1_q, s2_q, s3_q, filt_q, filt_d;
	logic f_dv, f_act, f_sd, f_rec;
	logic [3:0] f_rxd;
	logic tph_q, tph_d, texp, smp;
	logic [4:0] tcnt_q, tcnt_d;
	mii_tx_t cap_q, cap_d;
	logic rph_q, rph_d, rtog, rx_fall, pend_q, pend_d, rec_q;
	logic [4:0] rcnt_q, rcnt_d;
	rx_st_t rs_q, rs_d;
	mii_rx_t rxo_q, rxo_d;
	logic crs_q, crs_d, tgt;
	logic [3:0] ccnt_q, ccnt_d;

	function automatic logic [4:0] phase_len(input mode_t m, input logic rx,
		input logic hi);
		logic [4:0] n;
		n = 5'h01;
		case (m)
			MODE_100: n = 5'(`CYC_UP(`HALF100_NS));
			MODE_10_NIB: n = 5'(`CYC_UP(`HALF10_NS));
			MODE_10_SER:
			begin
				if (rx)
					n = 5'(`CYC_UP(`SER_RX_HALF_NS));
				else if (hi)
					n = 5'(`CYC_UP(`SER_TX_HI_NS));
				else
					n = 5'(`CYC_UP(`SER_TX_LO_NS));
			end
			default: n = 5'h01;
		endcase
		return n;
	endfunction

	// Phase that may be held longer during a clock source switch
	function automatic logic stretch_hi(input mode_t m);
		return m == MODE_10_SER;
	endfunction

	// Line pins: three flops, a change counts when stages two and three agree
	always_comb
	begin
		filt_d = (s3_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
	end
	assign {f_rxd, f_dv, f_act, f_sd, f_rec} = filt_q;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_q <= 8'h00;
			s2_q <= 8'h00;
			s3_q <= 8'h00;
			filt_q <= 8'h00;
		end
		else
		begin
			s1_q <= {line_rxd, line_rx_dv, line_act, line_sd, rec_sel};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	// Transmit clock; the MAC runs on it, so its pins are sampled directly
	always_comb
	begin
		texp = tcnt_q == phase_len(mode, 1'b0, tph_q) - 5'h01;
		tph_d = texp ? ~tph_q : tph_q;
		tcnt_d = texp ? 5'h00 : tcnt_q + 5'h01;
		smp = texp & ((mode == MODE_10_NIB) ? tph_q : ~tph_q);
		cap_d = smp ? mac_tx : cap_q;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			tph_q <= 1'b0;
			tcnt_q <= 5'h00;
			cap_q <= '0;
		end
		else
		begin
			tph_q <= tph_d;
			tcnt_q <= tcnt_d;
			cap_q <= cap_d;
		end
	end

	// line latency counted from the sampling edge
	tap_delay #(
		.W(5),
		.D(16)
	) u_tx_line (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.din(cap_d),
		.tap((mode == MODE_100) ? 4'(`TX100_LAT_CYC - 1) :
			4'(`TX10_LAT_CYC - 1)),
		.dout(line_tx)
	);

	// Receive clock with stretch on a reference/recovered switch
	always_comb
	begin
		rs_d = rs_q;
		rph_d = rph_q;
		rcnt_d = rcnt_q + 5'h01;
		rtog = 1'b0;
		case (rs_q)
			RS_RUN:
			begin
				if (rcnt_q == phase_len(mode, 1'b1, rph_q) - 5'h01)
				begin
					rcnt_d = 5'h00;
					// full phase first, then hold it
					if (pend_q && rph_q == stretch_hi(mode))
						rs_d = RS_STRETCH;
					else
						rtog = 1'b1;
				end
			end
			RS_STRETCH:
			begin
				if (rcnt_q == 5'(STRETCH_CYC - 1))
				begin
					rcnt_d = 5'h00;
					rtog = 1'b1;
					rs_d = RS_RUN;
				end
			end
			default:
			begin
				rs_d = RS_RUN;
				rcnt_d = 5'h00;
			end
		endcase
		if (rtog)
			rph_d = ~rph_q;
		rx_fall = rtog & rph_q;
		// A new switch arriving as the stretch ends stays pending
		pend_d = (pend_q & ~(rtog & (rs_q == RS_STRETCH))) | (f_rec ^ rec_q);
		// receive outputs launched at the falling edge
		rxo_d = rx_fall ? {f_dv, f_rxd} : rxo_q;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rs_q <= RS_RUN;
			rph_q <= 1'b0;
			rcnt_q <= 5'h00;
			pend_q <= 1'b0;
			rec_q <= 1'b0;
			rxo_q <= '0;
		end
		else
		begin
			rs_q <= rs_d;
			rph_q <= rph_d;
			rcnt_q <= rcnt_d;
			pend_q <= pend_d;
			rec_q <= f_rec;
			rxo_q <= rxo_d;
		end
	end

	// Carrier sense; the count already absorbs the synchroniser latency
	always_comb
	begin
		tgt = f_act & (f_sd | (mode != MODE_100));
		crs_d = crs_q;
		ccnt_d = 4'h0;
		if (tgt != crs_q)
		begin
			if (ccnt_q == (crs_q ? 4'(`CRS_OFF_CYC - 1) : 4'(`CRS_ON_CYC - 1)))
				crs_d = tgt;
			else
				ccnt_d = ccnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			crs_q <= 1'b0;
			ccnt_q <= 4'h0;
		end
		else
		begin
			crs_q <= crs_d;
			ccnt_q <= ccnt_d;
		end
	end

	assign tx_clk = tph_q;
	assign rx_clk = rph_q;
	assign mac_rx = rxo_q;
	assign crs = crs_q;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	nib_fall_smp_a: assert property (
		(smp && mode == MODE_10_NIB) |-> tph_q && !tph_d)
		else $error("nibble sample not on falling edge");
	ser_rise_smp_a: assert property (
		(smp && mode == MODE_10_SER) |-> !tph_q && tph_d)
		else $error("serial sample not on rising edge");
	ser_tx_shape_a: assert property (
		(mode == MODE_10_SER && $rose(tph_q)) |->
		##1 (!tph_q) [*3] ##1 tph_q)
		else $error("serial tx clock not one high three low");
	stretch_phase_a: assert property (
		(rs_q == RS_STRETCH) |-> rph_q == stretch_hi(mode))
		else $error("stretch on the wrong phase");
	nib_min_phase_a: assert property (
		(mode == MODE_10_NIB && $changed(rph_q)) |=>
		$stable(rph_q) [*7])
		else $error("nibble rx phase too short");
	ser_min_phase_a: assert property (
		(mode == MODE_10_SER && $changed(rph_q)) |=>
		$stable(rph_q))
		else $error("serial rx phase too short");
	tx100_lat_a: assert property (
		(smp && mode == MODE_100) |-> ##3 line_tx == $past(cap_q, 2))
		else $error("100 Mb/s line latency wrong");
	tx10_lat_a: assert property (
		(smp && mode != MODE_100) |-> ##15 line_tx == $past(cap_q, 14))
		else $error("10 Mb/s line latency wrong");
	crs_on_a: assert property (
		(mode == MODE_100 && $rose(crs_q)) |->
		$past(tgt, 1) && $past(tgt, 4))
		else $error("carrier sense rose early");
	crs_off_a: assert property (
		(mode == MODE_100 && $fell(crs_q)) |->
		!$past(tgt, 1) && !$past(tgt, 5))
		else $error("carrier sense fell early");
	rx_launch_a: assert property (
		$changed(rxo_q) |-> $fell(rph_q))
		else $error("rx outputs changed away from falling edge");
	nib_rx_hold_a: assert property (
		(mode == MODE_10_NIB && $changed(rxo_q)) |->
		!rph_q ##1 (!rph_q && $stable(rxo_q)) [*7])
		else $error("nibble rx data not stable around rise");

	stretch_seen_c: cover property (rs_q == RS_STRETCH && rtog);
	crs_cycle_c: cover property ($rose(crs_q) ##[1:200] $fell(crs_q));
	tx_frame_c: cover property ($rose(line_tx.en));
endmodule

// ==== rtl/tap_delay.sv ====
// Shift-register delay line with a selectable tap and registered output
`timescale 1ns/1ps
module tap_delay #(
	parameter int W = 5,
	parameter int D = 16
)
(
	input wire logic clk_sys, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic [W-1:0] din, // Value entering the line
	input wire logic [$clog2(D)-1:0] tap, // Stage whose value is output
	output logic [W-1:0] dout // Tap value, one register later
);
	logic [W-1:0] sr_q [D];
	logic [W-1:0] sr_d [D];
	logic [W-1:0] out_q;
	logic [W-1:0] out_d;

	always_comb
	begin
		sr_d[0] = din;
		for (int i = 1; i < D; i++)
			sr_d[i] = sr_q[i-1];
		out_d = sr_q[tap];
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < D; i++)
				sr_q[i] <= '0;
			out_q <= '0;
		end
		else
		begin
			sr_q <= sr_d;
			out_q <= out_d;
		end
	end

	assign dout = out_q;
endmodule

// ==== verif/mac_model.sv ====
// Stand-in MAC that drives transmit nibbles and takes receive data
`timescale 1ns/1ps
module mac_model
	import mii_phy_pkg::*;
(
	input wire logic tx_clk, // Transmit clock from the block
	input wire logic rx_clk, // Receive clock from the block
	input wire mii_rx_t mac_rx, // Receive valid and data
	input wire logic go, // Send random nibbles when high
	input wire logic slow, // Hold each nibble for two periods
	output mii_tx_t mac_tx, // Transmit enable and data
	output mii_rx_t rx_seen // Last receive value taken
);
	logic hold_q = 1'b0;
	initial mac_tx = '0;
	initial rx_seen = '0;
	always @(posedge tx_clk)
	begin
		hold_q <= slow && !hold_q;
		if (!(slow && hold_q))
			mac_tx <= #1 go ? mii_tx_t'($urandom) : '0;
	end
	always @(posedge rx_clk)
		rx_seen <= mac_rx;
endmodule

// ==== verif/mii_phy_timing_bench.sv ====
// Bench for the PHY-side MII timing block with a stand-in MAC
`timescale 1ns/1ps
module mii_phy_timing_bench;
	import mii_phy_pkg::*;
	localparam int STR = 3;
	typedef struct {mii_tx_t v; int due;} note_t;
	logic clk_sys = 1'b0, rstn = 1'b0, line_rx_dv = 1'b0, line_act = 1'b0;
	logic line_sd = 1'b0, rec_sel = 1'b0, go = 1'b0, slow = 1'b0;
	logic [3:0] line_rxd = 4'h0;
	mode_t mode = MODE_100;
	logic tx_clk, rx_clk, crs, tx_p, rx_p, tval, rval;
	mii_tx_t mac_tx, line_tx, mtx_p;
	mii_rx_t mac_rx, rx_seen, mrx_p;
	int err_count = 0, checked = 0, cyc = 0, hits = 0, tlen, rlen, rb;
	note_t q[$];
	logic [4:0] msk;
	assign msk = (mode == MODE_10_SER) ? 5'h11 : 5'h1F;
	initial forever #12.5 clk_sys = ~clk_sys;
	mii_phy_timing #(.STRETCH_CYC(STR)) DUT (.clk_sys(clk_sys), .rstn(rstn),
		.mode(mode), .tx_clk(tx_clk), .mac_tx(mac_tx), .rx_clk(rx_clk),
		.mac_rx(mac_rx), .crs(crs), .line_tx(line_tx), .line_rxd(line_rxd),
		.line_rx_dv(line_rx_dv), .line_act(line_act), .line_sd(line_sd),
		.rec_sel(rec_sel));
	mac_model mac (.tx_clk(tx_clk), .rx_clk(rx_clk), .mac_rx(mac_rx),
		.go(go), .slow(slow), .mac_tx(mac_tx), .rx_seen(rx_seen));
	task check(input string name, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task stop_test;
		$display("Counts: %0d compared, %0d mismatched", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Watches the outputs; transmit notes are taken at the sampling edge
	always @(negedge clk_sys)
	begin
		cyc++;
		rb = (mode == MODE_10_NIB) ? 8 : (mode == MODE_10_SER) ? 2 : 1;
		if (!rstn)
		begin
			q.delete();
			tval = 0;
			rval = 0;
		end
		else
		begin
			if ((mode == MODE_10_NIB) ? (tx_p && !tx_clk) : (!tx_p && tx_clk))
				q.push_back('{mtx_p, cyc + ((mode == MODE_100) ? 2 : 14)});
			if (q.size() > 0 && q[0].due == cyc)
			begin
				check("line_tx", line_tx & msk, q[0].v & msk);
				void'(q.pop_front());
			end
			if (tx_clk !== tx_p)
			begin
				if (tval)
					check("tx_phase", tlen, (mode == MODE_10_SER) ?
						(tx_p ? 1 : 3) : (rb == 8 ? 8 : 1));
				tval = 1;
				tlen = 0;
			end
			if (rx_clk !== rx_p)
			begin
				// Low phase stretches, except high in serial mode
				if (rval && ((mode == MODE_10_SER) == rx_p))
				begin
					check("rx_long", rlen >= rb && rlen <= rb + STR, 1);
					hits += (rlen == rb + STR);
				end
				else if (rval)
					check("rx_fixed", rlen, rb);
				rval = 1;
				rlen = 0;
			end
			if (mac_rx !== mrx_p)
				check("rx_launch", rx_p && !rx_clk, 1);
		end
		tlen++;
		rlen++;
		{tx_p, rx_p, mtx_p, mrx_p} = {tx_clk, rx_clk, mac_tx, mac_rx};
		// Ceiling well above the roughly 2000 cycles the tests need
		if (cyc > 20000)
		begin
			err_count++;
			stop_test();
		end
	end
	task rx_test;
		logic [4:0] v;
		v = 5'($urandom);
		{line_rx_dv, line_rxd} = v;
		tick(50);
		@(posedge rx_clk);
		#1 check("rx_seen", rx_seen & msk, v & msk);
	endtask
	task crs_test(input logic sd, input logic on);
		line_sd = sd;
		line_act = 1'b1;
		tick(7);
		check("crs_early", crs, 0);
		tick(2);
		check("crs_on", crs, on);
		line_act = 1'b0;
		tick(8);
		check("crs_hold", crs, on);
		tick(2);
		check("crs_off", crs, 0);
	endtask
	initial
	begin
		void'($urandom(16341));
		for (int m = 0; m < 3; m++)
		begin
			rstn = 1'b0;
			go = 1'b0;
			mode = mode_t'(m);
			tick(2);
			rstn = 1'b1;
			go = 1'b1;
			tick(200);
			slow = 1'b1;
			tick(200);
			slow = 1'b0;
			hits = 0;
			rec_sel = ~rec_sel;
			tick(60);
			rec_sel = ~rec_sel;
			tick(60);
			check("stretch", hits > 0, 1);
			rx_test();
			tick(1);
			rx_test();
			tick(1);
			if (mode == MODE_100)
				crs_test(1'b0, 1'b0);
			crs_test(1'b1, 1'b1);
			$display("Test of mode %0d done", m);
		end
		stop_test();
	end
endmodule
